/* File: hdl/arlc_cfg.svh */
// Constants of the alt-mode redriver lane control block.
// Assumes a 250 MHz core clock and an external register access agent.
// Function
// - LFPS present switches that receiver's equalization off
// - Without LFPS, gain from straps or registers
// - Track USB U-state from line conditions
// - Poll receiver detect, then terminate and redrive
// - Snoop native AUX writes to 0x00101, 0x00600
// - D3 disables lanes, else captured count
// - Snoop on after reset, off by control
// - Snoop only in register-based configuration
// - Strap mode: all four lanes on hotplug when the display enable pin is high
// - Snooped values land in register 0x12
// - Latch four-level straps at reset release
// - Drop strap pull resistors after hold time
// - Four-level input decodes to two bits
// - Two straps per path, registers may override
// - Select strap level 0 means pin mode
// - Lanes pass only when enabled and hotplug
`ifndef ARLC_CFG_SVH
`define ARLC_CFG_SVH

`define ARLC_CLK_PERIOD_NS       4
`define ARLC_STRAP_HOLD_NS       1000
`define ARLC_STRAP_HOLD_CYC      ((`ARLC_STRAP_HOLD_NS + `ARLC_CLK_PERIOD_NS - 1) / `ARLC_CLK_PERIOD_NS)
`define ARLC_RXDET_INTV_MS       12
`define ARLC_RXDET_INTV_CYC      (`ARLC_RXDET_INTV_MS * 1000000 / `ARLC_CLK_PERIOD_NS)
`define ARLC_U2_IDLE_CYC         1000
`define ARLC_U3_IDLE_CYC         4000

`define ARLC_OFS_SNOOP_STATUS    8'h12
`define ARLC_OFS_SNOOP_CONTROL   8'h13
`define ARLC_OFS_LANE_MASK       8'h14
`define ARLC_OFS_GAIN_USB        8'h20
`define ARLC_OFS_GAIN_DISPLAY    8'h21
`define ARLC_OFS_USB_STATE       8'h22

`define ARLC_CTL_SNOOP_OFF_BIT   0
`define ARLC_CTL_DISP_EN_BIT     1
`define ARLC_CTL_GAIN_OVR_BIT    2
`define ARLC_CONTROL_RESET       8'h00
`define ARLC_LANE_MASK_RESET     4'hF
`define ARLC_GAIN_RESET          4'h0

`define ARLC_AUX_CMD_NATIVE_WR   4'h8
`define ARLC_DPCD_LANE_COUNT     20'h00101
`define ARLC_DPCD_POWER_STATE    20'h00600
`define ARLC_POWER_D3            3'h2
`define ARLC_LEVEL_ZERO          2'h0

`endif

/* File: hdl/arlc_pkg.sv */
// Types shared by the alt-mode redriver lane control block.
// Assumes nothing of its surroundings.
package arlc_pkg;
    typedef enum logic [2:0] {
        USB_DISC = 3'h0,
        USB_U0   = 3'h1,
        USB_U1   = 3'h3,
        USB_U2   = 3'h2,
        USB_U3   = 3'h6
    } arlc_usb_state_type;

    typedef enum logic [2:0] {
        AUX_CMD  = 3'h0,
        AUX_AMID = 3'h1,
        AUX_ALOW = 3'h3,
        AUX_LEN  = 3'h2,
        AUX_DATA = 3'h6,
        AUX_SKIP = 3'h7
    } arlc_aux_state_type;
endpackage

/* File: hdl/arlc_strap4.sv */
// Four-level strap synchroniser and latch, one generate slice per pin.
// Assumes each pin arrives as a two-bit comparator code, asynchronous.
`include "arlc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module arlc_strap4 #(
    parameter int NUM_PINS = 7,
    parameter int HOLD_CYC = `ARLC_STRAP_HOLD_CYC
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // Pin codes
    input  wire logic [2*NUM_PINS-1:0] pin_code,
    // Latched levels
    output logic      [2*NUM_PINS-1:0] strap_level,
    output logic                       strap_valid,
    output logic                       pull_en
);
    logic [2*NUM_PINS-1:0] sync1;
    logic [2*NUM_PINS-1:0] sync2;
    logic [2*NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0]   agree;
    logic [15:0]           hold_cnt;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_code;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            assign agree[i] = (sync2[2*i+1:2*i] == sync3[2*i+1:2*i]);
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            strap_level <= '0;
            strap_valid <= 1'b0;
        end else if (!strap_valid && hold_cnt >= 16'(3) && &agree) begin
            strap_level <= sync3;
            strap_valid <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hold_cnt <= '0;
            pull_en  <= 1'b1;
        end else if (pull_en) begin
            if (strap_valid && hold_cnt >= 16'(HOLD_CYC)) begin
                pull_en <= 1'b0;
            end else if (hold_cnt != 16'hFFFF) begin
                hold_cnt <= hold_cnt + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/arlc_top.sv */
// Lane and equalization control of the alt-mode redriver switch.
// Assumes same-clock AUX byte framing and register access agent;
// line-condition inputs come asynchronously from the analog front end.
`include "arlc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module arlc_top #(
    parameter int RXDET_INTV_CYC = `ARLC_RXDET_INTV_CYC,
    parameter int U2_IDLE_CYC    = `ARLC_U2_IDLE_CYC,
    parameter int U3_IDLE_CYC    = `ARLC_U3_IDLE_CYC,
    parameter int HOLD_CYC       = `ARLC_STRAP_HOLD_CYC
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Four-level strap codes
    input  wire logic [1:0] config_select_code,
    input  wire logic [3:0] usb_path_a_gain_straps,
    input  wire logic [3:0] usb_path_b_gain_straps,
    input  wire logic [3:0] display_gain_straps,
    output logic            strap_pull_en,
    // Line conditions
    input  wire logic [1:0] lfps_active,
    input  wire logic       rx_detected,
    input  wire logic       elec_idle,
    input  wire logic       ss_rate,
    input  wire logic       hotplug_sense_in,
    input  wire logic       display_enable_pin,
    // Receiver control
    output logic            rxdet_start,
    output logic            rx_term_en,
    output logic            redrive_en,
    output logic [1:0]      eq_enable,
    output logic [3:0]      usb_a_gain,
    output logic [3:0]      usb_b_gain,
    output logic [3:0]      display_gain,
    output logic [2:0]      usb_power_state,
    output logic [3:0]      display_lane_en,
    // AUX byte stream
    input  wire logic       aux_start,
    input  wire logic       aux_byte_valid,
    input  wire logic [7:0] aux_byte,
    // Register access
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd_en,
    output logic [7:0]      reg_rdata
);
    logic [13:0]                 strap_level;
    logic                        strap_valid;
    logic [1:0]                  lfps_s1, lfps_s2, lfps_s3, lfps_q;
    logic [3:0]                  line_s1, line_s2, line_s3, line_q;
    logic                        reg_mode;
    logic                        snoop_on;
    logic [7:0]                  control;
    logic [3:0]                  lane_mask;
    logic [3:0]                  gain_one, gain_two, gain_ss, gain_disp_reg;
    logic [2:0]                  cap_lanes;
    logic [2:0]                  cap_power;
    logic [31:0]                 rxdet_cnt;
    logic [31:0]                 idle_cnt;
    arlc_pkg::arlc_usb_state_type usb_state;
    arlc_pkg::arlc_aux_state_type aux_state;
    logic [19:0]                 aux_addr;
    logic [3:0]                  next_lanes;

    arlc_strap4 #(.NUM_PINS(7), .HOLD_CYC(HOLD_CYC)) u_strap (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .pin_code    ({config_select_code, usb_path_a_gain_straps,
                       usb_path_b_gain_straps, display_gain_straps}),
        .strap_level (strap_level),
        .strap_valid (strap_valid),
        .pull_en     (strap_pull_en)
    );

    // select level 0 is pin mode
    assign reg_mode = strap_valid && (strap_level[13:12] != `ARLC_LEVEL_ZERO);
    assign snoop_on = reg_mode && !control[`ARLC_CTL_SNOOP_OFF_BIT];

    // Three-stage sync; change taken when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lfps_s1 <= '0;
            lfps_s2 <= '0;
            lfps_s3 <= '0;
            lfps_q  <= '0;
            line_s1 <= 4'h2;
            line_s2 <= 4'h2;
            line_s3 <= 4'h2;
            line_q  <= 4'h2;
        end else begin
            lfps_s1 <= lfps_active;
            lfps_s2 <= lfps_s1;
            lfps_s3 <= lfps_s2;
            line_s1 <= {hotplug_sense_in, rx_detected, elec_idle, ss_rate};
            line_s2 <= line_s1;
            line_s3 <= line_s2;
            for (int k = 0; k < 2; k++) begin
                if (lfps_s2[k] == lfps_s3[k]) lfps_q[k] <= lfps_s3[k];
            end
            for (int k = 0; k < 4; k++) begin
                if (line_s2[k] == line_s3[k]) line_q[k] <= line_s3[k];
            end
        end
    end

    // Register writes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            control       <= `ARLC_CONTROL_RESET;
            lane_mask     <= `ARLC_LANE_MASK_RESET;
            gain_one      <= `ARLC_GAIN_RESET;
            gain_two      <= `ARLC_GAIN_RESET;
            gain_ss       <= `ARLC_GAIN_RESET;
            gain_disp_reg <= `ARLC_GAIN_RESET;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `ARLC_OFS_SNOOP_CONTROL: control <= reg_wdata;
                `ARLC_OFS_LANE_MASK:     lane_mask <= reg_wdata[3:0];
                `ARLC_OFS_GAIN_USB: begin
                    gain_one <= reg_wdata[3:0];
                    gain_two <= reg_wdata[7:4];
                end
                `ARLC_OFS_GAIN_DISPLAY: begin
                    gain_ss       <= reg_wdata[3:0];
                    gain_disp_reg <= reg_wdata[7:4];
                end
                default: ;
            endcase
        end
    end

    // Register reads, one cycle latency; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `ARLC_OFS_SNOOP_STATUS:  reg_rdata <= {1'b0, cap_power, 1'b0, cap_lanes};
                `ARLC_OFS_SNOOP_CONTROL: reg_rdata <= control;
                `ARLC_OFS_LANE_MASK:     reg_rdata <= {4'h0, lane_mask};
                `ARLC_OFS_GAIN_USB:      reg_rdata <= {gain_two, gain_one};
                `ARLC_OFS_GAIN_DISPLAY:  reg_rdata <= {gain_disp_reg, gain_ss};
                `ARLC_OFS_USB_STATE:     reg_rdata <= {5'h00, usb_state};
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            eq_enable    <= 2'h0;
            usb_a_gain   <= 4'h0;
            usb_b_gain   <= 4'h0;
            display_gain <= 4'h0;
        end else begin
            eq_enable <= ~lfps_q;
            if (reg_mode && control[`ARLC_CTL_GAIN_OVR_BIT]) begin
                usb_a_gain   <= gain_one;
                usb_b_gain   <= gain_ss;
                display_gain <= gain_disp_reg;
            end else begin
                usb_a_gain   <= strap_level[11:8];
                usb_b_gain   <= strap_level[7:4];
                display_gain <= strap_level[3:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rxdet_cnt   <= '0;
            rxdet_start <= 1'b0;
        end else begin
            rxdet_start <= 1'b0;
            if (usb_state == arlc_pkg::USB_DISC) begin
                if (rxdet_cnt >= 32'(RXDET_INTV_CYC - 1)) begin
                    rxdet_cnt   <= '0;
                    rxdet_start <= 1'b1;
                end else begin
                    rxdet_cnt <= rxdet_cnt + 32'h1;
                end
            end else begin
                rxdet_cnt <= '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            usb_state <= arlc_pkg::USB_DISC;
            idle_cnt  <= '0;
        end else if (!line_q[2]) begin
            usb_state <= arlc_pkg::USB_DISC;
            idle_cnt  <= '0;
        end else begin
            case (usb_state)
                arlc_pkg::USB_DISC: usb_state <= arlc_pkg::USB_U0;
                arlc_pkg::USB_U0: begin
                    idle_cnt <= '0;
                    if (line_q[1] && !line_q[0] && lfps_q == 2'h0) usb_state <= arlc_pkg::USB_U1;
                end
                arlc_pkg::USB_U1, arlc_pkg::USB_U2, arlc_pkg::USB_U3: begin
                    if ((lfps_q != 2'h0) || (!line_q[1] && line_q[0])) begin
                        usb_state <= arlc_pkg::USB_U0;
                        idle_cnt  <= '0;
                    end else begin
                        if (idle_cnt != 32'hFFFF_FFFF) idle_cnt <= idle_cnt + 32'h1;
                        if (idle_cnt >= 32'(U3_IDLE_CYC)) usb_state <= arlc_pkg::USB_U3;
                        else if (idle_cnt >= 32'(U2_IDLE_CYC)) usb_state <= arlc_pkg::USB_U2;
                    end
                end
                default: usb_state <= arlc_pkg::USB_DISC;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rx_term_en      <= 1'b0;
            redrive_en      <= 1'b0;
            usb_power_state <= 3'h0;
        end else begin
            rx_term_en      <= (usb_state != arlc_pkg::USB_DISC);
            redrive_en      <= (usb_state != arlc_pkg::USB_DISC);
            usb_power_state <= usb_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            aux_state <= arlc_pkg::AUX_CMD;
            aux_addr  <= '0;
        end else if (aux_start) begin
            aux_state <= arlc_pkg::AUX_CMD;
        end else if (aux_byte_valid) begin
            case (aux_state)
                arlc_pkg::AUX_CMD: begin
                    aux_addr[19:16] <= aux_byte[3:0];
                    aux_state <= (aux_byte[7:4] == `ARLC_AUX_CMD_NATIVE_WR) ?
                                 arlc_pkg::AUX_AMID : arlc_pkg::AUX_SKIP;
                end
                arlc_pkg::AUX_AMID: begin
                    aux_addr[15:8] <= aux_byte;
                    aux_state      <= arlc_pkg::AUX_ALOW;
                end
                arlc_pkg::AUX_ALOW: begin
                    aux_addr[7:0] <= aux_byte;
                    aux_state     <= arlc_pkg::AUX_LEN;
                end
                arlc_pkg::AUX_LEN:  aux_state <= arlc_pkg::AUX_DATA;
                arlc_pkg::AUX_DATA: aux_state <= arlc_pkg::AUX_SKIP;
                arlc_pkg::AUX_SKIP: aux_state <= arlc_pkg::AUX_SKIP;
                default:            aux_state <= arlc_pkg::AUX_SKIP;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cap_lanes <= 3'h0;
            cap_power <= 3'h1;
        end else if (snoop_on && aux_byte_valid && !aux_start &&
                     aux_state == arlc_pkg::AUX_DATA) begin
            if (aux_addr == `ARLC_DPCD_LANE_COUNT) cap_lanes <= aux_byte[2:0];
            if (aux_addr == `ARLC_DPCD_POWER_STATE) cap_power <= aux_byte[2:0];
        end
    end

    always_comb begin
        next_lanes = 4'h0;
        if (!reg_mode) begin
            next_lanes = display_enable_pin ? 4'hF : 4'h0;
        end else if (!control[`ARLC_CTL_DISP_EN_BIT]) begin
            next_lanes = 4'h0;
        end else if (!snoop_on) begin
            next_lanes = lane_mask;
        end else if (cap_power != `ARLC_POWER_D3) begin
            case (cap_lanes)
                3'h1:    next_lanes = 4'h1;
                3'h2:    next_lanes = 4'h3;
                3'h4:    next_lanes = 4'hF;
                default: next_lanes = 4'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            display_lane_en <= 4'h0;
        end else begin
            display_lane_en <= line_q[3] ? next_lanes : 4'h0;
        end
    end
endmodule
`default_nettype wire

/* File: dv/arlc_top_assertions.sv */
// Checker of the lane control block, bound to arlc_top.
// Sees only the top module's ports; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module arlc_top_assertions #(
    parameter int HOLD_CYC = 10
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_b,
    // Watched ports
    input wire logic       strap_pull_en,
    input wire logic [1:0] lfps_active,
    input wire logic       rx_detected,
    input wire logic       hotplug_sense_in,
    input wire logic       rxdet_start,
    input wire logic       rx_term_en,
    input wire logic       redrive_en,
    input wire logic [1:0] eq_enable,
    input wire logic [2:0] usb_power_state,
    input wire logic [3:0] display_lane_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    int pull_cnt;
    // Slack covers strap sync stages; the hold counts from reset release alongside them
    always_ff @(posedge core_clk) begin
        if (!rst_b || !strap_pull_en) begin
            pull_cnt <= 0;
        end else begin
            pull_cnt <= pull_cnt + 1;
        end
    end
    a_lfps_eq_off: assert property (lfps_active[0] [*6] |-> !eq_enable[0])
        else $error("eq on during lfps");
    a_idle_eq_on: assert property (!lfps_active[1] [*6] |-> eq_enable[1])
        else $error("eq off without lfps");
    a_disc_no_rx: assert property (!rx_detected [*7] |-> usb_power_state == 3'h0)
        else $error("state not disc without receiver");
    a_term_follows: assert property (rx_term_en == redrive_en &&
        rx_term_en == (usb_power_state != 3'h0)) else $error("termination mismatch");
    a_rxdet_pulse: assert property (rxdet_start |=> !rxdet_start)
        else $error("detect start too long");
    a_hotplug_lanes: assert property (!hotplug_sense_in [*6] |-> display_lane_en == 4'h0)
        else $error("lanes on without hotplug");
    a_pull_held: assert property ($rose(rst_b) |-> strap_pull_en [*8])
        else $error("pulls dropped before latch");
    a_pull_drops: assert property (strap_pull_en |-> pull_cnt < HOLD_CYC + 24)
        else $error("pulls never dropped");
    a_pull_stays_off: assert property (!strap_pull_en |=> !strap_pull_en)
        else $error("pulls came back");
    a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved");
    c_all_lanes: cover property (display_lane_en == 4'hF);
    c_deep_sleep: cover property (usb_power_state == 3'h6);
    c_pull_drop: cover property ($fell(strap_pull_en));
endmodule
`default_nettype wire

/* File: dv/arlc_far_model.sv */
// Far side: USB line conditions and display source AUX byte stream.
// Assumes the bench calls its tasks; drives at falling edges.
`timescale 1ns/1ps
`default_nettype none
module arlc_far_model (
    // Clock
    input  wire logic       core_clk,
    // USB line conditions
    output logic [1:0]      lfps_active,
    output logic            rx_detected,
    output logic            elec_idle,
    output logic            ss_rate,
    output logic            hotplug_sense_in,
    // AUX byte stream
    output logic            aux_start,
    output logic            aux_byte_valid,
    output logic [7:0]      aux_byte
);
    initial begin
        lfps_active = 2'h0;
        rx_detected = 1'b0;
        elec_idle = 1'b1;
        ss_rate = 1'b0;
        hotplug_sense_in = 1'b0;
        aux_start = 1'b0;
        aux_byte_valid = 1'b0;
        aux_byte = 8'h5A;
    end
    task automatic line(input logic [1:0] lf, input logic rx, input logic idle,
                        input logic rate, input logic hp);
        @(negedge core_clk);
        lfps_active = lf;
        rx_detected = rx;
        elec_idle = idle;
        ss_rate = rate;
        hotplug_sense_in = hp;
    endtask
    // Byte lane inverted once released, never left at the old value
    task automatic put(input logic [7:0] b, input int slow);
        @(negedge core_clk);
        aux_byte_valid = 1'b1;
        aux_byte = b;
        @(negedge core_clk);
        aux_byte_valid = 1'b0;
        aux_byte = ~b;
        repeat (slow) @(negedge core_clk);
    endtask
    task automatic aux_req(input logic [3:0] cmd, input logic [19:0] addr,
                           input logic [7:0] data, input int slow);
        @(negedge core_clk);
        aux_start = 1'b1;
        @(negedge core_clk);
        aux_start = 1'b0;
        put({cmd, addr[19:16]}, slow);
        put(addr[15:8], slow);
        put(addr[7:0], slow);
        put(8'h00, slow);
        put(data, slow);
    endtask
endmodule
`default_nettype wire

/* File: dv/arlc_top_tb_top.sv */
// Self-checking bench of the lane control block with its far-side model.
// Assumes one 250 MHz clock; long counts shortened through parameters.
`timescale 1ns/1ps
`default_nettype none
module arlc_top_tb_top;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic [1:0] config_select_code = 2'h3;
    logic [3:0] usb_path_a_gain_straps = 4'h0;
    logic [3:0] usb_path_b_gain_straps = 4'h0;
    logic [3:0] display_gain_straps = 4'h0;
    logic       display_enable_pin = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_rd_en = 1'b0;
    logic       strap_pull_en, rx_detected, elec_idle, ss_rate, hotplug_sense_in;
    logic       rxdet_start, rx_term_en, redrive_en, aux_start, aux_byte_valid;
    logic [1:0] lfps_active, eq_enable;
    logic [2:0] usb_power_state;
    logic [3:0] usb_a_gain, usb_b_gain, display_gain, display_lane_en, sa, sb, sd;
    logic [7:0] aux_byte, reg_rdata, lf;
    logic [7:0] tab [4] = '{8'h03, 8'h01, 8'h02, 8'h04};
    int         err_total = 0;
    int         check_count = 0;
    int         cnt;

    always #2 core_clk = ~core_clk;

    arlc_top #(.RXDET_INTV_CYC(50), .U2_IDLE_CYC(20), .U3_IDLE_CYC(40), .HOLD_CYC(10))
    u_arlc_top (.core_clk, .rst_b, .config_select_code, .usb_path_a_gain_straps,
        .usb_path_b_gain_straps, .display_gain_straps, .strap_pull_en, .lfps_active,
        .rx_detected, .elec_idle, .ss_rate, .hotplug_sense_in, .display_enable_pin,
        .rxdet_start, .rx_term_en, .redrive_en, .eq_enable, .usb_a_gain, .usb_b_gain,
        .display_gain, .usb_power_state, .display_lane_en, .aux_start, .aux_byte_valid,
        .aux_byte, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata);

    arlc_far_model u_arlc_far_model (.core_clk, .lfps_active, .rx_detected, .elec_idle,
        .ss_rate, .hotplug_sense_in, .aux_start, .aux_byte_valid, .aux_byte);

    task automatic results();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        check(reg_rdata, exp);
    endtask

    // Straps must settle before reset release, so they are set here while reset is held
    task automatic do_reset(input logic [1:0] sel);
        @(negedge core_clk);
        rst_b = 1'b0;
        config_select_code = sel;
        sa = 4'($urandom);
        sb = 4'($urandom);
        sd = 4'($urandom);
        usb_path_a_gain_straps = sa;
        usb_path_b_gain_straps = sb;
        display_gain_straps = sd;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (30) @(negedge core_clk);
    endtask

    function automatic logic [7:0] lane_exp(input logic [7:0] n);
        case (n[2:0])
            3'h1: lane_exp = 8'h01;
            3'h2: lane_exp = 8'h03;
            3'h4: lane_exp = 8'h0F;
            default: lane_exp = 8'h00;
        endcase
    endfunction

    task automatic aux_chk(input logic [19:0] a, input logic [7:0] d, input logic [7:0] l);
        u_arlc_far_model.aux_req(4'h8, a, d, $urandom_range(2));
        repeat (4) @(negedge core_clk);
        check(8'(display_lane_en), l);
    endtask

    task automatic usb_chk(input logic [1:0] lf, input logic rx, input logic idle,
                           input logic rate, input int w, input logic [7:0] st);
        u_arlc_far_model.line(lf, rx, idle, rate, 1'b0);
        repeat (w) @(negedge core_clk);
        check(8'(usb_power_state), st);
    endtask

    // Whole run is near 730 cycles; limit sits well past it
    initial begin
        #80000;
        err_total++;
        results();
    end

    initial begin
        void'($urandom(35784));
        do_reset(2'h3);
        usb_path_a_gain_straps = ~sa;
        usb_path_b_gain_straps = ~sb;
        display_gain_straps = ~sd;
        repeat (8) @(negedge core_clk);
        check(8'(usb_a_gain), 8'(sa));
        check(8'(usb_b_gain), 8'(sb));
        check(8'(display_gain), 8'(sd));
        check(8'(strap_pull_en), 8'h00);
        rd_chk(8'h12, 8'h10);
        rd_chk(8'h13, 8'h00);
        rd_chk(8'h14, 8'h0F);
        rd_chk(8'h55, 8'h00);
        wr(8'h12, 8'hFF);
        rd_chk(8'h12, 8'h10);
        wr(8'h13, 8'h02);
        u_arlc_far_model.line(2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            aux_chk(20'h00101, tab[i], lane_exp(tab[i]));
            rd_chk(8'h12, 8'h10 | tab[i]);
        end
        aux_chk(20'h00600, 8'h02, 8'h00);
        rd_chk(8'h12, 8'h24);
        aux_chk(20'h00600, 8'h01, 8'h0F);
        u_arlc_far_model.aux_req(4'h9, 20'h00101, 8'h01, 0);
        repeat (4) @(negedge core_clk);
        rd_chk(8'h12, 8'h14);
        wr(8'h14, 8'h05);
        wr(8'h13, 8'h03);
        aux_chk(20'h00101, 8'h01, 8'h05);
        rd_chk(8'h12, 8'h14);
        wr(8'h21, 8'hA5);
        wr(8'h13, 8'h07);
        repeat (2) @(negedge core_clk);
        check(8'(display_gain), 8'h0A);
        check(8'(usb_b_gain), 8'h05);
        usb_chk(2'h0, 1'b0, 1'b1, 1'b0, 8, 8'h00);
        check(8'(display_lane_en), 8'h00);
        usb_chk(2'h0, 1'b1, 1'b0, 1'b1, 8, 8'h01);
        check(8'({rx_term_en, redrive_en}), 8'h03);
        usb_chk(2'h0, 1'b1, 1'b1, 1'b0, 8, 8'h03);
        usb_chk(2'h0, 1'b1, 1'b1, 1'b0, 22, 8'h02);
        usb_chk(2'h0, 1'b1, 1'b1, 1'b0, 22, 8'h06);
        rd_chk(8'h22, 8'h06);
        usb_chk(2'h1, 1'b1, 1'b1, 1'b0, 8, 8'h01);
        usb_chk(2'h0, 1'b0, 1'b1, 1'b0, 8, 8'h00);
        cnt = 0;
        repeat (200) begin
            @(negedge core_clk);
            if (rxdet_start === 1'b1) cnt++;
        end
        check(8'(cnt >= 3 && cnt <= 5), 8'h01);
        repeat (10) begin
            lf = 8'($urandom_range(3));
            usb_chk(lf[1:0], 1'b0, 1'b1, 1'b0, 8, 8'h00);
            check(8'(eq_enable), {6'h00, ~lf[1:0]});
        end
        do_reset(2'h0);
        display_enable_pin = 1'b1;
        u_arlc_far_model.line(2'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        aux_chk(20'h00101, 8'h01, 8'h0F);
        rd_chk(8'h12, 8'h10);
        check(8'(usb_a_gain), 8'(sa));
        display_enable_pin = 1'b0;
        repeat (4) @(negedge core_clk);
        check(8'(display_lane_en), 8'h00);
        results();
    end
endmodule

bind arlc_top arlc_top_assertions #(.HOLD_CYC(HOLD_CYC)) u_arlc_top_assertions (
    .core_clk, .rst_b, .strap_pull_en, .lfps_active, .rx_detected, .hotplug_sense_in,
    .rxdet_start, .rx_term_en, .redrive_en, .eq_enable, .usb_power_state,
    .display_lane_en, .reg_rd_en, .reg_rdata);
`default_nettype wire
